/* File: include/psl_pkg.sv */
package psl_pkg;

  // management register port geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_LEDCFG = 5'h17;
  localparam logic [4:0] REG_ADDR = 5'h19;

  // control register fields
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int CTRL_ISO_BIT = 10;
  localparam int CTRL_AN_BIT = 12;
  localparam int CTRL_SPEED_BIT = 13;

  // advertisement register fields
  localparam int ADV_SEL_LSB = 0;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  localparam int ADV_10HD_BIT = 5;
  localparam int ADV_10FD_BIT = 6;
  localparam int ADV_100HD_BIT = 7;
  localparam int ADV_100FD_BIT = 8;

  // indicator configuration and address register fields
  localparam int LEDCFG_ACT_BIT = 7;
  localparam int ADDR_LSB = 11;
  localparam int ADDR_BYP_SCR_BIT = 0;
  localparam int ADDR_BYP_CODE_BIT = 1;
  localparam int ADDR_BYP_ALIGN_BIT = 2;

  // reset values
  localparam logic ISO_RST = 1'h0;
  localparam logic ACT_MODE_RST = 1'h0;
  localparam logic [4:0] MGMT_ADDR_RST = 5'h00;
  localparam logic [4:0] ADDR_ZERO = 5'h00;

  // cycles after reset release before straps are latched; covers the two synchroniser stages
  localparam logic [2:0] STRAP_SETTLE_CYC = 3'h3;

  typedef enum logic [0:0] {
    PH_SAMPLE = 1'h0,
    PH_RUN = 1'h1
  } psl_phase_t;

  // strap levels, packed in the order they are synchronised
  typedef struct packed {
    logic [4:0] phy_addr;
    logic autoneg_en;
    logic fast_fd;
    logic fast_hd;
    logic scr_byp;
    logic code_byp;
    logic align_byp;
    logic slow_hd;
    logic slow_fd;
  } psl_strap_t;

  // live status from the surrounding phy core, same clock
  typedef struct packed {
    logic rx_active;
    logic tx_active;
    logic link_ok;
    logic collision;
    logic an_speed_100;
    logic an_full_duplex;
  } psl_status_t;

  // data-path bypass selects
  typedef struct packed {
    logic scrambler;
    logic coding;
    logic align;
  } psl_bypass_t;

endpackage

/* File: rtl/psl_sync.sv */
`timescale 1ns/1ns
module psl_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // two-stage synchroniser; only the second stage leaves the module
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule

/* File: rtl/psl_ind_pin.sv */
`timescale 1ns/1ns
module psl_ind_pin (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic strap_level,
  input wire logic active,
  output logic pin_o,
  output logic pin_oe
);

  logic o_r;
  logic oe_r;
  logic o_nxt;

  // the led hangs on the side the strap resistor set, so the lit level equals the strap level
  assign o_nxt = enable ? (active ? strap_level : ~strap_level) : 1'h0;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      o_r <= 1'h0;
      oe_r <= 1'h0;
    end else begin
      o_r <= o_nxt;
      oe_r <= enable;
    end
  end

  assign pin_o = o_r;
  assign pin_oe = oe_r;

endmodule

/* File: rtl/psl_strap_led.sv */
// Operation
// R01: latch five address straps as management address
// R02: strap address zero enters isolate after reset
// R03: scrambler strap high bypasses scramble and descramble
// R04: coding strap high bypasses 4B/5B encoder
// R05: alignment strap high gives raw symbol interface
// R06: autonegotiation strap sets autonegotiation enable
// R07: ability straps fill advertisement bits when negotiating
// R08: without autonegotiation, ability straps force speed, duplex
// R09: receive indicator lit while receiving
// R10: transmit or activity indicator per bit 7 of 17h
// R11: link indicator lit while link valid
// R12: collision indicator lit on collision
// R13: duplex indicator lit in full duplex
// R14: speed indicator lit at 100 Mbit/s
// R15: shared pins input during capture, output afterwards
// R16: isolate bit initialised from zero strap address
// R17: isolate ignores tx inputs, floats mii outputs
// R18: address writable at 19h; zero isolates, bit unchanged
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module psl_strap_led
  import psl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // strap-only pins
  input wire logic [4:0] phy_addr_strap,
  input wire logic autoneg_enable_strap,
  input wire logic fast_full_duplex_strap,
  input wire logic fast_half_duplex_strap,
  // shared strap / indicator pins, then the receive indicator, which carries no strap
  input wire logic tx_indicator_i,
  output logic tx_indicator_o,
  output logic tx_indicator_oe,
  input wire logic col_indicator_i,
  output logic col_indicator_o,
  output logic col_indicator_oe,
  input wire logic link_indicator_i,
  output logic link_indicator_o,
  output logic link_indicator_oe,
  input wire logic duplex_indicator_i,
  output logic duplex_indicator_o,
  output logic duplex_indicator_oe,
  input wire logic speed_indicator_i,
  output logic speed_indicator_o,
  output logic speed_indicator_oe,
  output logic rx_indicator_o,
  output logic rx_indicator_oe,
  // phy core side
  input wire psl_status_t core_status,
  output psl_bypass_t bypass,
  output logic autoneg_enable,
  output logic [DATA_W-1:0] adv_reg,
  output logic speed_100,
  output logic full_duplex,
  output logic [4:0] mgmt_addr,
  output logic mii_isolate,
  output logic mii_tx_ignore,
  output logic mii_out_float,
  output logic strap_phase
);

  psl_phase_t phase_r;
  psl_phase_t phase_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  psl_strap_t strap_s;
  psl_strap_t strap_r;
  logic [12:0] strap_raw;
  logic [12:0] strap_q;
  logic [4:0] mgmt_addr_r;
  logic isolate_r;
  logic act_mode_r;
  logic speed_r;
  logic fd_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // strap pins come from the board: synchronise before anything looks at them
  assign strap_raw = {phy_addr_strap, autoneg_enable_strap, fast_full_duplex_strap,
                      fast_half_duplex_strap, tx_indicator_i, col_indicator_i,
                      link_indicator_i, duplex_indicator_i, speed_indicator_i};

  psl_sync #(.W(13)) u_strap_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .d(strap_raw),
    .q(strap_q)
  );

  assign strap_s = psl_strap_t'(strap_q);

  // capture phase: pins stay inputs until the synchronised levels have settled
  wire in_run = (phase_r == PH_RUN);
  wire capture = (phase_r == PH_SAMPLE) && (cnt_r == STRAP_SETTLE_CYC);

  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    unique case (phase_r)
      PH_SAMPLE: begin
        cnt_nxt = cnt_r + 3'h1;
        if (capture) begin
          phase_nxt = PH_RUN; // R15
          cnt_nxt = cnt_r;
        end
      end
      PH_RUN: begin
        cnt_nxt = cnt_r;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_r <= PH_SAMPLE;
      cnt_r <= 3'h0;
    end else begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // straps are latched once and held; reset brings a fresh capture
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_r <= '0;
    end else if (capture) begin
      strap_r <= strap_s; // R01 R03 R04 R05 R06 R15
    end
  end

  // register decode
  wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  wire wr_ledcfg = reg_wr && (reg_addr == REG_LEDCFG);
  wire wr_addr = reg_wr && (reg_addr == REG_ADDR);

  // address and isolate bit: capture outranks a write landing in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mgmt_addr_r <= MGMT_ADDR_RST;
      isolate_r <= ISO_RST;
    end else if (capture) begin
      mgmt_addr_r <= strap_s.phy_addr; // R01
      isolate_r <= (strap_s.phy_addr == ADDR_ZERO); // R16 R02
    end else begin
      if (wr_addr) begin
        mgmt_addr_r <= reg_wdata[ADDR_LSB +: 5]; // R18
      end
      if (wr_ctrl) begin
        isolate_r <= reg_wdata[CTRL_ISO_BIT];
      end
    end
  end

  // transmit-only versus activity mode of the shared indicator
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      act_mode_r <= ACT_MODE_RST;
    end else if (wr_ledcfg) begin
      act_mode_r <= reg_wdata[LEDCFG_ACT_BIT]; // R10
    end
  end

  // forced mode picks the best strapped ability: 100 full, 100 half, 10 full, 10 half
  wire forced_speed = strap_r.fast_fd | strap_r.fast_hd; // R08
  wire forced_fd = strap_r.fast_fd | (~strap_r.fast_hd & strap_r.slow_fd); // R08
  wire speed_nxt = strap_r.autoneg_en ? core_status.an_speed_100 : forced_speed;
  wire fd_nxt = strap_r.autoneg_en ? core_status.an_full_duplex : forced_fd;

  // operating mode registered so indicators and outputs never glitch
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      speed_r <= 1'h0;
      fd_r <= 1'h0;
    end else begin
      speed_r <= in_run & speed_nxt; // R08
      fd_r <= in_run & fd_nxt; // R08
    end
  end

  // advertisement carries abilities only while negotiating; selector always present
  wire an_adv = strap_r.autoneg_en;
  always_comb begin
    adv_reg = '0;
    adv_reg[ADV_SEL_LSB +: 5] = ADV_SELECTOR;
    adv_reg[ADV_10HD_BIT] = an_adv & strap_r.slow_hd; // R07
    adv_reg[ADV_10FD_BIT] = an_adv & strap_r.slow_fd; // R07
    adv_reg[ADV_100HD_BIT] = an_adv & strap_r.fast_hd; // R07
    adv_reg[ADV_100FD_BIT] = an_adv & strap_r.fast_fd; // R07
  end

  // register read mux; unmapped addresses read zero
  wire [DATA_W-1:0] ctrl_view = DATA_W'(strap_r.autoneg_en) << CTRL_AN_BIT
                              | DATA_W'(speed_r) << CTRL_SPEED_BIT
                              | DATA_W'(isolate_r) << CTRL_ISO_BIT
                              | DATA_W'(fd_r) << CTRL_DUPLEX_BIT;
  wire [DATA_W-1:0] ledcfg_view = DATA_W'(act_mode_r) << LEDCFG_ACT_BIT;
  wire [DATA_W-1:0] addr_view = DATA_W'(mgmt_addr_r) << ADDR_LSB
                              | DATA_W'(strap_r.scr_byp) << ADDR_BYP_SCR_BIT
                              | DATA_W'(strap_r.code_byp) << ADDR_BYP_CODE_BIT
                              | DATA_W'(strap_r.align_byp) << ADDR_BYP_ALIGN_BIT;
  wire [DATA_W-1:0] rd_mux = (reg_addr == REG_CTRL) ? ctrl_view :
                             (reg_addr == REG_ADV) ? adv_reg :
                             (reg_addr == REG_LEDCFG) ? ledcfg_view :
                             (reg_addr == REG_ADDR) ? addr_view : '0;
  assign rdata_nxt = reg_rd ? rd_mux : '0;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // indicator activity terms
  wire tx_act = act_mode_r ? (core_status.rx_active | core_status.tx_active)
                           : core_status.tx_active; // R10

  psl_ind_pin u_tx_pin (
    .ref_clk(ref_clk), .rstn(rstn), .enable(in_run), .strap_level(strap_r.scr_byp),
    .active(tx_act), .pin_o(tx_indicator_o), .pin_oe(tx_indicator_oe)
  ); // R10 R15

  psl_ind_pin u_col_pin (
    .ref_clk(ref_clk), .rstn(rstn), .enable(in_run), .strap_level(strap_r.code_byp),
    .active(core_status.collision), .pin_o(col_indicator_o), .pin_oe(col_indicator_oe)
  ); // R12

  psl_ind_pin u_link_pin (
    .ref_clk(ref_clk), .rstn(rstn), .enable(in_run), .strap_level(strap_r.align_byp),
    .active(core_status.link_ok), .pin_o(link_indicator_o), .pin_oe(link_indicator_oe)
  ); // R11

  psl_ind_pin u_duplex_pin (
    .ref_clk(ref_clk), .rstn(rstn), .enable(in_run), .strap_level(strap_r.slow_hd),
    .active(fd_r), .pin_o(duplex_indicator_o), .pin_oe(duplex_indicator_oe)
  ); // R13

  psl_ind_pin u_speed_pin (
    .ref_clk(ref_clk), .rstn(rstn), .enable(in_run), .strap_level(strap_r.slow_fd),
    .active(speed_r), .pin_o(speed_indicator_o), .pin_oe(speed_indicator_oe)
  ); // R14

  // receive pin carries no strap; its pull-down makes low the lit level
  psl_ind_pin u_rx_pin (
    .ref_clk(ref_clk), .rstn(rstn), .enable(in_run), .strap_level(1'h0),
    .active(core_status.rx_active), .pin_o(rx_indicator_o), .pin_oe(rx_indicator_oe)
  ); // R09

  // core-facing outputs, all straight from flops or simple gates of them
  assign bypass.scrambler = strap_r.scr_byp; // R03
  assign bypass.coding = strap_r.code_byp; // R04
  assign bypass.align = strap_r.align_byp; // R05
  assign autoneg_enable = strap_r.autoneg_en; // R06
  assign speed_100 = speed_r;
  assign full_duplex = fd_r;
  assign mgmt_addr = mgmt_addr_r;
  // a zero address isolates without touching the isolate bit; management keeps answering
  assign mii_isolate = in_run & (isolate_r | (mgmt_addr_r == ADDR_ZERO)); // R02 R18
  assign mii_tx_ignore = mii_isolate; // R17
  assign mii_out_float = mii_isolate; // R17
  assign strap_phase = ~in_run;
  assign reg_rdata = rdata_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_addr_capture: assert property (capture |=> mgmt_addr_r == $past(strap_s.phy_addr)) // R01
    else $error("management address not taken from straps");
  a_iso_init: assert property (capture |=> isolate_r == ($past(strap_s.phy_addr) == ADDR_ZERO)) // R16
    else $error("isolate bit not initialised from strap address");
  a_zero_isolates: assert property (in_run && mgmt_addr_r == ADDR_ZERO |-> mii_isolate && mii_out_float) // R02
    else $error("zero address did not isolate");
  a_addr_write: assert property (in_run && wr_addr |=> mgmt_addr == $past(reg_wdata[ADDR_LSB +: 5]) && $stable(isolate_r)) // R18
    else $error("address write wrong or disturbed isolate bit");
  a_pins_input: assert property (!in_run |-> !tx_indicator_oe && !col_indicator_oe && !link_indicator_oe
                                 && !duplex_indicator_oe && !speed_indicator_oe) // R15
    else $error("shared pin driven during strap capture");
  a_straps_held: assert property (in_run && $past(in_run) |-> $stable(strap_r)) // R15
    else $error("latched straps changed after capture");
  a_adv_bits: assert property (in_run && strap_r.autoneg_en |-> adv_reg[ADV_100FD_BIT] == strap_r.fast_fd
                               && adv_reg[ADV_10HD_BIT] == strap_r.slow_hd) // R07
    else $error("advertisement bits do not follow straps");
  a_forced_mode: assert property (in_run && !strap_r.autoneg_en && strap_r.fast_fd |=> speed_100 && full_duplex) // R08
    else $error("forced mode does not follow straps");
  a_tx_only: assert property (in_run && !act_mode_r && !core_status.tx_active && core_status.rx_active
                              |=> tx_indicator_o == ~strap_r.scr_byp) // R10
    else $error("transmit indicator lit by receive in transmit mode");
  a_activity: assert property (in_run && act_mode_r && core_status.rx_active
                               |=> tx_indicator_o == strap_r.scr_byp) // R10
    else $error("activity indicator dark during receive");
  a_link_lit: assert property (in_run && core_status.link_ok |=> link_indicator_oe
                               && link_indicator_o == strap_r.align_byp) // R11
    else $error("link indicator dark with valid link");
  a_rx_lit: assert property (in_run && core_status.rx_active |=> rx_indicator_oe && !rx_indicator_o) // R09
    else $error("receive indicator dark while receiving");
  a_col_lit: assert property (in_run && core_status.collision |=> col_indicator_o == strap_r.code_byp) // R12
    else $error("collision indicator dark");
  a_speed_duplex: assert property (in_run && $past(in_run) |=> speed_indicator_o == (strap_r.slow_fd ~^ $past(speed_r))
                                   && duplex_indicator_o == (strap_r.slow_hd ~^ $past(fd_r))) // R13 R14
    else $error("speed or duplex indicator disagrees with mode");
  a_bypass_out: assert property (in_run |-> bypass == {strap_r.scr_byp, strap_r.code_byp, strap_r.align_byp}) // R03 R04 R05
    else $error("bypass selects disagree with straps");

endmodule

/* File: sim/psl_board.sv */
`timescale 1ns/1ns
// board side: strap resistors hold each shared pin while the device leaves it undriven
module psl_board
  import psl_pkg::*;
(
  input wire psl_strap_t strap,
  input wire logic [4:0] drv_o,
  input wire logic [4:0] drv_oe,
  output logic [4:0] pin
);
  // resistor level per shared pin, order tx, col, link, duplex, speed
  wire logic [4:0] res_level;
  assign res_level = {strap.scr_byp, strap.code_byp, strap.align_byp, strap.slow_hd, strap.slow_fd};
  // the driver wins when enabled; otherwise the resistor level shows, never a stale driven value
  assign pin = (drv_oe & drv_o) | (~drv_oe & res_level);
endmodule

/* File: sim/tb_psl_strap_led.sv */
`timescale 1ns/1ns
module tb_psl_strap_led;
  import psl_pkg::*;
  logic ref_clk, rstn, reg_wr, reg_rd;
  logic [4:0] reg_addr, mgmt_addr, pin, pin_o, pin_oe;
  logic [15:0] reg_wdata, reg_rdata, adv_reg, d, adv;
  logic rx_o, rx_oe, autoneg_enable, speed_100, full_duplex;
  logic mii_isolate, mii_tx_ignore, mii_out_float, strap_phase, iso;
  psl_strap_t strap, c;
  psl_status_t core_status;
  psl_bypass_t bypass;
  int fail_count, samples_checked;
  // strap sets: every forced mode, address zero and nonzero, each bypass both ways
  psl_strap_t cfgs [6] = '{13'h00de, 13'h1323, 13'h1f08, 13'h0175, 13'h0a03, 13'h02a1};
  psl_status_t sts [4] = '{6'h3f, 6'h00, 6'h2a, 6'h15};

  psl_strap_led u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phy_addr_strap(strap.phy_addr),
    .autoneg_enable_strap(strap.autoneg_en), .fast_full_duplex_strap(strap.fast_fd),
    .fast_half_duplex_strap(strap.fast_hd), .tx_indicator_i(pin[4]), .tx_indicator_o(pin_o[4]),
    .tx_indicator_oe(pin_oe[4]), .col_indicator_i(pin[3]), .col_indicator_o(pin_o[3]),
    .col_indicator_oe(pin_oe[3]), .link_indicator_i(pin[2]), .link_indicator_o(pin_o[2]),
    .link_indicator_oe(pin_oe[2]), .duplex_indicator_i(pin[1]), .duplex_indicator_o(pin_o[1]),
    .duplex_indicator_oe(pin_oe[1]), .speed_indicator_i(pin[0]), .speed_indicator_o(pin_o[0]),
    .speed_indicator_oe(pin_oe[0]), .rx_indicator_o(rx_o), .rx_indicator_oe(rx_oe),
    .core_status(core_status), .bypass(bypass), .autoneg_enable(autoneg_enable), .adv_reg(adv_reg),
    .speed_100(speed_100), .full_duplex(full_duplex), .mgmt_addr(mgmt_addr), .mii_isolate(mii_isolate),
    .mii_tx_ignore(mii_tx_ignore), .mii_out_float(mii_out_float), .strap_phase(strap_phase)
  );

  psl_board u_board (.strap(strap), .drv_o(pin_o), .drv_oe(pin_oe), .pin(pin));

  // 10 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic port_check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // register words are compared only on the bits that the map defines
  task automatic reg_check(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask);
    samples_checked++;
    if ((got & mask) !== (exp & mask)) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got & mask, exp & mask);
    end
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [15:0] wd);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [4:0] a, output logic [15:0] rd);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // forced mode priority 100FD, 100HD, 10FD, 10HD; negotiated mode follows the core
  function automatic logic [1:0] mode_exp(psl_strap_t k, psl_status_t s);
    if (k.autoneg_en) begin
      return {s.an_speed_100, s.an_full_duplex};
    end
    return {k.fast_fd | k.fast_hd, k.fast_fd | (~k.fast_hd & k.slow_fd)};
  endfunction

  // a lit pin shows its strap level, a dark one the inverse; receive lights low
  function automatic logic [5:0] led_exp(psl_strap_t k, psl_status_t s, logic act, logic [1:0] m);
    logic [4:0] lit;
    logic [4:0] on;
    lit = {k.scr_byp, k.code_byp, k.align_byp, k.slow_hd, k.slow_fd};
    on = {s.tx_active | (act & s.rx_active), s.collision, s.link_ok, m[0], m[1]};
    return {~(on ^ lit), ~s.rx_active};
  endfunction

  task automatic do_reset(input psl_strap_t k);
    @(posedge ref_clk);
    rstn <= 1'b0;
    strap <= k;
    core_status <= 6'h00;
    repeat (2) @(posedge ref_clk);
    #1 port_check({strap_phase, pin_oe, rx_oe}, 16'h0040);
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  task automatic led_check(input psl_status_t s, input logic act);
    logic [1:0] m;
    @(posedge ref_clk);
    core_status <= s;
    repeat (3) @(posedge ref_clk);
    #1 m = mode_exp(c, s);
    port_check({speed_100, full_duplex}, m);
    port_check({pin_oe, rx_oe, pin, rx_o}, {6'h3f, led_exp(c, s, act, m)});
    reg_read(REG_CTRL, d);
    reg_check(d, {2'h0, m[1], c.autoneg_en, 1'h0, iso, 1'h0, m[0], 8'h00}, 16'h3500);
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #1_000_000;
    fail_count++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    strap = cfgs[0];
    core_status = 6'h00;
    fail_count = 0;
    samples_checked = 0;
    foreach (cfgs[i]) begin
      c = cfgs[i];
      do_reset(c);
      iso = (c.phy_addr == ADDR_ZERO);
      adv = {7'h00, c.fast_fd, c.fast_hd, c.slow_fd, c.slow_hd, ADV_SELECTOR};
      if (!c.autoneg_en) begin
        adv[8:5] = 4'h0;
      end
      port_check({strap_phase, mgmt_addr, mii_isolate, mii_tx_ignore, mii_out_float}, {c.phy_addr, {3{iso}}});
      port_check({bypass, autoneg_enable}, {c.scr_byp, c.code_byp, c.align_byp, c.autoneg_en});
      port_check(adv_reg, adv);
      reg_read(REG_ADV, d);
      reg_check(d, adv, 16'hffff);
      reg_read(REG_ADDR, d);
      reg_check(d, {c.phy_addr, 8'h00, c.align_byp, c.code_byp, c.scr_byp}, 16'hf807);
      reg_read(REG_LEDCFG, d);
      reg_check(d, 16'h0000, 16'h0080);
      foreach (sts[j]) begin
        led_check(sts[j], 1'b0);
      end
      reg_write(REG_LEDCFG, 16'h0080);
      led_check(6'h20, 1'b1);
      led_check(6'h10, 1'b1);
    end
    // read data fall back to zero after their one cycle; unmapped reads give zero
    reg_read(REG_ADV, d);
    @(posedge ref_clk);
    #1 port_check(reg_rdata, 16'h0000);
    reg_read(5'h1f, d);
    reg_check(d, 16'h0000, 16'hffff);
    // zero address isolates without touching the isolate bit
    reg_write(REG_ADDR, 16'h0000);
    port_check({mgmt_addr, mii_isolate, mii_out_float}, 16'h0003);
    reg_read(REG_CTRL, d);
    reg_check(d, 16'h0000, 16'h0400);
    reg_write(REG_ADDR, 16'h9800);
    port_check({mgmt_addr, mii_isolate}, {5'h13, 1'h0});
    reg_read(REG_ADDR, d);
    reg_check(d, 16'h9800, 16'hf800);
    // isolate bit is writable, the autonegotiation bit beside it is not
    reg_write(REG_CTRL, 16'h0400);
    port_check({mii_isolate, mii_tx_ignore}, 16'h0003);
    reg_read(REG_CTRL, d);
    reg_check(d, 16'h1400, 16'h1400);
    // strap changes after capture are ignored
    @(posedge ref_clk);
    strap.phy_addr <= 5'h1c;
    strap.autoneg_en <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 port_check({mgmt_addr, autoneg_enable}, {5'h13, 1'h1});
    complete_run();
  end
endmodule
